// [common/flash_status_pkg.sv]
// constants for the flash status and protection register block
// assumes a single clock domain; status bytes are eight bits wide
package flash_status_pkg;
  // status byte one field positions
  localparam int BUSY_POS      = 0;
  localparam int WPL_POS       = 1;
  localparam int RANGE_LO_POS  = 2;
  localparam int RANGE_HI_POS  = 4;
  localparam int ANCHOR_POS    = 5;
  localparam int UNIT_POS      = 6;
  localparam int GUARD_LO_POS  = 7;
  // status byte two field positions
  localparam int GUARD_HI_POS  = 0;
  localparam int FOUR_LINE_POS = 1;
  localparam int PROG_PAUSE_POS = 2;
  localparam int OTP_LO_POS    = 3;
  localparam int OTP_HI_POS    = 5;
  localparam int INVERT_POS    = 6;
  localparam int ERASE_PAUSE_POS = 7;
  // status byte three field positions
  localparam int LOCK_SCHEME_POS = 2;
  localparam int FAST_CLK_POS  = 4;
  localparam int STRENGTH_LO_POS = 5;
  localparam int STRENGTH_HI_POS = 6;
  localparam int PIN_FUNC_POS  = 7;
  // reset values of the stored bytes
  localparam logic [7:0] BYTE_ONE_RESET   = 8'h00;
  localparam logic [7:0] BYTE_TWO_RESET   = 8'h00;
  localparam logic [7:0] BYTE_THREE_RESET = 8'h10;
  // writable masks; read-only and reserved bits excluded, except reserved byte three bit 0
  localparam logic [7:0] BYTE_ONE_WMASK   = 8'hfc;
  localparam logic [7:0] BYTE_TWO_WMASK   = 8'h43;
  localparam logic [7:0] BYTE_THREE_WMASK = 8'hf5;
  localparam logic [7:0] OTP_MASK         = 8'h38;
  // instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_RESUME        = 8'h7a;
  // guard modes (hi, lo)
  typedef enum logic [1:0] {
    GUARD_SOFTWARE = 2'b00,
    GUARD_PIN      = 2'b01,
    GUARD_LOCKDOWN = 2'b10,
    GUARD_FOREVER  = 2'b11
  } guard_mode_t;
  // drive strength percentages
  localparam logic [6:0] STRENGTH_00 = 7'd50;
  localparam logic [6:0] STRENGTH_01 = 7'd25;
  localparam logic [6:0] STRENGTH_10 = 7'd75;
  localparam logic [6:0] STRENGTH_11 = 7'd100;
endpackage : flash_status_pkg

// [verilog/status_write_gate.sv]
// decides whether a status write may proceed under the guard mode
// assumes guard bits and pin level are sampled on the same clock
`timescale 1ns/1ps
module status_write_gate (
  // guard state
  input  wire logic [1:0] guard_in,
  input  wire logic       wpl_in,
  input  wire logic       protect_pin_n_in,
  input  wire logic       four_line_in,
  // decision
  output logic            allow_out
);
  // the protect pin only counts while it is a control pin
  wire pin_low = ~protect_pin_n_in & ~four_line_in;

  always_comb begin
    case (flash_status_pkg::guard_mode_t'(guard_in))
      flash_status_pkg::GUARD_SOFTWARE: allow_out = wpl_in;
      flash_status_pkg::GUARD_PIN:      allow_out = wpl_in & ~pin_low;
      flash_status_pkg::GUARD_LOCKDOWN: allow_out = 1'b0;
      flash_status_pkg::GUARD_FOREVER:  allow_out = 1'b0;
      default:                          allow_out = 1'b0;
    endcase
  end
endmodule : status_write_gate

// [verilog/pin_function_map.sv]
// maps configuration bits onto pin roles and drive strength
// assumes all inputs come from registers of the status block
`timescale 1ns/1ps
module pin_function_map (
  // configuration
  input  wire logic       four_line_in,
  input  wire logic       pin_func_in,
  input  wire logic [1:0] strength_in,
  // pin roles
  output logic            data_line_two_en_out,
  output logic            data_line_three_en_out,
  output logic            hold_en_out,
  output logic            pin_reset_en_out,
  output logic [6:0]      strength_pct_out
);
  // hold or reset only while pins are not data lines
  assign data_line_two_en_out   = four_line_in;
  assign data_line_three_en_out = four_line_in;
  assign hold_en_out      = ~four_line_in & ~pin_func_in;
  assign pin_reset_en_out = ~four_line_in & pin_func_in;

  // strength code to percent
  always_comb begin
    case (strength_in)
      2'b00:   strength_pct_out = flash_status_pkg::STRENGTH_00;
      2'b01:   strength_pct_out = flash_status_pkg::STRENGTH_01;
      2'b10:   strength_pct_out = flash_status_pkg::STRENGTH_10;
      2'b11:   strength_pct_out = flash_status_pkg::STRENGTH_11;
      default: strength_pct_out = flash_status_pkg::STRENGTH_00;
    endcase
  end
endmodule : pin_function_map

// [verilog/flash_status_protect_regs.sv]
// status and protection register bank of a serial flash device
// assumes the command decoder hands over one strobe per instruction,
// and that the array engine reports when program/erase work ends.
`timescale 1ns/1ps
module flash_status_protect_regs #(
  parameter int BLOCK_LOCKS = 286,
  parameter int WRITE_CYCLES = 4
) (
  // clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // software reset strobe
  input  wire logic       soft_reset_in,
  // instruction strobes from the command decoder
  input  wire logic       op_valid_in,
  input  wire logic [7:0] op_code_in,
  // status write request with its three bytes
  input  wire logic       status_write_in,
  input  wire logic [1:0] status_write_count_in,
  input  wire logic [7:0] write_byte_one_in,
  input  wire logic [7:0] write_byte_two_in,
  input  wire logic [7:0] write_byte_three_in,
  // array engine handshake
  input  wire logic       array_start_in,
  input  wire logic       array_done_in,
  // individual lock updates
  input  wire logic       lock_set_in,
  input  wire logic       lock_clear_in,
  input  wire logic       lock_all_in,
  input  wire logic [8:0] lock_index_in,
  // pins
  input  wire logic       protect_pin_n_in,
  // status bytes
  output logic [7:0]      status_byte_one_out,
  output logic [7:0]      status_byte_two_out,
  output logic [7:0]      status_byte_three_out,
  // protection and pin roles
  output logic            write_permit_latch_out,
  output logic            busy_out,
  output logic            use_block_locks_out,
  output logic            fast_clock_standby_out,
  output logic [2:0]      otp_locked_out,
  output logic            lock_bit_out,
  output logic            data_line_two_en_out,
  output logic            data_line_three_en_out,
  output logic            hold_en_out,
  output logic            pin_reset_en_out,
  output logic [6:0]      strength_pct_out
);
  // elaboration checks
  // the nine-bit index compare cannot represent a count of 512
  if (BLOCK_LOCKS < 1 || BLOCK_LOCKS > 511) begin : g_bad_locks
    $error("BLOCK_LOCKS must be 1 to 511");
  end
  if (WRITE_CYCLES < 1 || WRITE_CYCLES > 255) begin : g_bad_wc
    $error("WRITE_CYCLES must be 1 to 255");
  end

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARRAY = 2'b01,
    ST_SWRITE = 2'b10
  } busy_state_t;

  // stored state
  logic [7:0]  status_byte_one_reg, status_byte_one_next;
  logic [7:0]  status_byte_two_reg, status_byte_two_next;
  logic [7:0]  status_byte_three_reg, status_byte_three_next;
  logic        write_permit_latch_reg, write_permit_latch_next;
  busy_state_t state_reg, state_next;
  logic [7:0]  wait_reg, wait_next;
  logic [BLOCK_LOCKS-1:0] lock_reg;
  logic        allow;

  // decoded instruction strobes
  wire is_wren = op_valid_in &&
                 op_code_in == flash_status_pkg::OP_WRITE_ENABLE;
  wire is_wrdi = op_valid_in &&
                 op_code_in == flash_status_pkg::OP_WRITE_DISABLE;
  wire is_susp = op_valid_in && op_code_in == flash_status_pkg::OP_SUSPEND;
  wire is_resm = op_valid_in && op_code_in == flash_status_pkg::OP_RESUME;
  wire idle    = state_reg == ST_IDLE;
  // busy device ignores status writes and write enable; other strobes still act
  wire do_swrite = status_write_in && idle;
  wire accept    = do_swrite && allow;
  wire [1:0] guard = {status_byte_two_reg[flash_status_pkg::GUARD_HI_POS],
                      status_byte_one_reg[flash_status_pkg::GUARD_LO_POS]};
  wire four_line = status_byte_two_reg[flash_status_pkg::FOUR_LINE_POS];
  wire [7:0] wait_load = 8'(WRITE_CYCLES);

  status_write_gate u_gate (
    .guard_in         (guard),
    .wpl_in           (write_permit_latch_reg),
    .protect_pin_n_in (protect_pin_n_in),
    .four_line_in     (four_line),
    .allow_out        (allow)
  );

  // merge only the writable bits; otp locks may only rise
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic [7:0] val,
                                       input logic [7:0] mask);
    merge = (cur & ~mask) | (val & mask);
  endfunction : merge

  // status byte next values
  always_comb begin
    status_byte_one_next   = status_byte_one_reg;
    status_byte_two_next   = status_byte_two_reg;
    status_byte_three_next = status_byte_three_reg;
    if (accept) begin
      status_byte_one_next = merge(status_byte_one_reg, write_byte_one_in,
                                   flash_status_pkg::BYTE_ONE_WMASK);
      if (status_write_count_in >= 2'd2) begin
        status_byte_two_next = merge(status_byte_two_reg,
          write_byte_two_in, flash_status_pkg::BYTE_TWO_WMASK);
        status_byte_two_next = status_byte_two_next |
          (write_byte_two_in & flash_status_pkg::OTP_MASK);
      end
      if (status_write_count_in == 2'd3) begin
        status_byte_three_next = merge(status_byte_three_reg,
          write_byte_three_in, flash_status_pkg::BYTE_THREE_WMASK);
      end
    end
    // paused flags; set beats clear in the same cycle
    if (is_resm) begin
      status_byte_two_next[flash_status_pkg::ERASE_PAUSE_POS] = 1'b0;
      status_byte_two_next[flash_status_pkg::PROG_PAUSE_POS]  = 1'b0;
    end
    if (is_susp) begin
      status_byte_two_next[flash_status_pkg::ERASE_PAUSE_POS] = 1'b1;
      status_byte_two_next[flash_status_pkg::PROG_PAUSE_POS]  = 1'b1;
    end
    status_byte_one_next[flash_status_pkg::BUSY_POS] = 1'b0;
    status_byte_one_next[flash_status_pkg::WPL_POS]  = 1'b0;
  end

  // write permit latch: write disable, an idle status write request and array completion clear; enable sets and wins
  always_comb begin
    write_permit_latch_next = write_permit_latch_reg;
    if (is_wrdi || do_swrite) begin
      write_permit_latch_next = 1'b0;
    end
    if (state_reg == ST_ARRAY && array_done_in) begin
      write_permit_latch_next = 1'b0;
    end
    if (is_wren && idle) begin
      write_permit_latch_next = 1'b1;
    end
  end

  // busy sequencing
  always_comb begin
    state_next = state_reg;
    wait_next  = wait_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_SWRITE;
          wait_next  = wait_load;
        end else if (array_start_in && write_permit_latch_reg) begin
          state_next = ST_ARRAY;
        end
      end
      ST_ARRAY: begin
        if (array_done_in) begin
          state_next = ST_IDLE;
        end
      end
      ST_SWRITE: begin
        if (wait_reg <= 8'd1) begin
          state_next = ST_IDLE;
          wait_next  = 8'h00;
        end else begin
          wait_next = wait_reg - 8'd1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // registers; software reset keeps nonvolatile bits but drops lockdown
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_byte_one_reg    <= flash_status_pkg::BYTE_ONE_RESET;
      status_byte_two_reg    <= flash_status_pkg::BYTE_TWO_RESET;
      status_byte_three_reg  <= flash_status_pkg::BYTE_THREE_RESET;
      write_permit_latch_reg <= 1'b0;
      state_reg              <= ST_IDLE;
      wait_reg               <= 8'h00;
    end else if (ce_in) begin
      if (soft_reset_in) begin
        write_permit_latch_reg <= 1'b0;
        state_reg              <= ST_IDLE;
        wait_reg               <= 8'h00;
        status_byte_one_reg    <= status_byte_one_reg;
        status_byte_two_reg    <= status_byte_two_reg;
        status_byte_three_reg  <= status_byte_three_reg;
        if (guard == 2'b10) begin
          status_byte_one_reg[flash_status_pkg::GUARD_LO_POS] <= 1'b0;
          status_byte_two_reg[flash_status_pkg::GUARD_HI_POS] <= 1'b0;
        end
      end else begin
        status_byte_one_reg    <= status_byte_one_next;
        status_byte_two_reg    <= status_byte_two_next;
        status_byte_three_reg  <= status_byte_three_next;
        write_permit_latch_reg <= write_permit_latch_next;
        state_reg              <= state_next;
        wait_reg               <= wait_next;
      end
    end
  end

  // individual block locks, all locked at reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_reg <= '1;
    end else if (ce_in) begin
      if (soft_reset_in || lock_all_in) begin
        lock_reg <= '1;
      end else if (lock_set_in && lock_index_in < 9'(BLOCK_LOCKS)) begin
        lock_reg[lock_index_in] <= 1'b1;
      end else if (lock_clear_in && lock_index_in < 9'(BLOCK_LOCKS)) begin
        lock_reg[lock_index_in] <= 1'b0;
      end
    end
  end

  pin_function_map u_pins (
    .four_line_in           (four_line),
    .pin_func_in            (
      status_byte_three_reg[flash_status_pkg::PIN_FUNC_POS]),
    .strength_in            (status_byte_three_reg[
                              flash_status_pkg::STRENGTH_HI_POS:
                              flash_status_pkg::STRENGTH_LO_POS]),
    .data_line_two_en_out   (data_line_two_en_out),
    .data_line_three_en_out (data_line_three_en_out),
    .hold_en_out            (hold_en_out),
    .pin_reset_en_out       (pin_reset_en_out),
    .strength_pct_out       (strength_pct_out)
  );

  // read views with live busy and latch bits
  assign busy_out               = state_reg != ST_IDLE;
  assign write_permit_latch_out = write_permit_latch_reg;
  assign status_byte_one_out    = {status_byte_one_reg[7:2],
                                   write_permit_latch_reg, busy_out};
  assign status_byte_two_out    = status_byte_two_reg;
  assign status_byte_three_out  = status_byte_three_reg;
  assign use_block_locks_out =
    status_byte_three_reg[flash_status_pkg::LOCK_SCHEME_POS];
  assign fast_clock_standby_out =
    status_byte_three_reg[flash_status_pkg::FAST_CLK_POS];
  assign otp_locked_out = status_byte_two_reg[flash_status_pkg::OTP_HI_POS:
                                              flash_status_pkg::OTP_LO_POS];
  // out-of-range index reads as locked
  assign lock_bit_out = (lock_index_in < 9'(BLOCK_LOCKS)) ?
                        lock_reg[lock_index_in] : 1'b1;
endmodule : flash_status_protect_regs

// [tb/flash_status_sva.sv]
// checker for the status and protection register bank
// assumes one clock; sees only the ports of the bank
`timescale 1ns/1ps
module flash_status_sva #(
  parameter int WRITE_CYCLES = 4
) (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       ce_in,
  // requests
  input wire logic       soft_reset_in,
  input wire logic       op_valid_in,
  input wire logic [7:0] op_code_in,
  input wire logic       status_write_in,
  input wire logic       protect_pin_n_in,
  // results
  input wire logic [7:0] status_byte_one_out,
  input wire logic [7:0] status_byte_two_out,
  input wire logic [7:0] status_byte_three_out,
  input wire logic       write_permit_latch_out,
  input wire logic       busy_out,
  input wire logic       use_block_locks_out,
  input wire logic       fast_clock_standby_out,
  input wire logic       data_line_two_en_out,
  input wire logic       data_line_three_en_out,
  input wire logic       hold_en_out,
  input wire logic       pin_reset_en_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // the busy run below is unrolled for the default length only
  if (WRITE_CYCLES != 4) begin : g_bad_wc
    $error("checker expects WRITE_CYCLES of 4");
  end
  // guard mode and every stored, writable bit
  wire logic [1:0]  guard_w = {status_byte_two_out[0], status_byte_one_out[7]};
  wire logic [19:0] keep_w = {status_byte_one_out[7:2],
    status_byte_two_out[6:3], status_byte_two_out[1:0], status_byte_three_out};
  wire logic op_w = op_valid_in && ce_in;
  // busy length is fixed at the default of four cycles
  sequence s_write_taken;
    status_write_in && ce_in && !busy_out && write_permit_latch_out &&
      !soft_reset_in && guard_w == 2'b00;
  endsequence
  sequence s_busy_run;
    busy_out[*4] ##1 !busy_out;
  endsequence
  sequence s_write_refused;
    status_write_in && ce_in && !soft_reset_in && !op_valid_in &&
      (guard_w[1] || (guard_w == 2'b00 && !write_permit_latch_out) ||
      (guard_w == 2'b01 && !protect_pin_n_in && !status_byte_two_out[1]));
  endsequence
  a_write_busy_run: assert property (s_write_taken |=> s_busy_run)
    else $error("status write busy time wrong");
  a_refused_keeps_bits: assert property (
    s_write_refused |=> $stable(keep_w))
    else $error("refused status write changed bits");
  a_refused_clears_latch: assert property (
    s_write_refused and !busy_out |=> !write_permit_latch_out)
    else $error("refused status write kept latch");
  a_wren_sets_latch: assert property (op_w && op_code_in == 8'h06 &&
    !busy_out && !status_write_in && !soft_reset_in |=> write_permit_latch_out)
    else $error("write enable did not set latch");
  a_wrdi_clears_latch: assert property (
    op_w && op_code_in == 8'h04 |=> !write_permit_latch_out)
    else $error("write disable did not clear latch");
  a_suspend_sets_flags: assert property (
    op_w && !soft_reset_in && op_code_in == 8'h75 |=>
    status_byte_two_out[7] && status_byte_two_out[2])
    else $error("suspend flags not set");
  a_resume_clears_flags: assert property (
    op_w && !soft_reset_in && op_code_in == 8'h7a |=>
    !status_byte_two_out[7] && !status_byte_two_out[2])
    else $error("resume flags not cleared");
  a_byte_one_mirror: assert property (
    status_byte_one_out[1:0] == {write_permit_latch_out, busy_out})
    else $error("byte one low bits differ from flags");
  a_otp_stays_set: assert property (
    ($past(status_byte_two_out[5:3]) & ~status_byte_two_out[5:3]) == 3'h0)
    else $error("otp lock bit cleared");
  a_four_line_pins: assert property (status_byte_two_out[1] |->
    data_line_two_en_out && data_line_three_en_out && !hold_en_out &&
    !pin_reset_en_out)
    else $error("four line pin roles wrong");
  a_pin_select_role: assert property (!status_byte_two_out[1] |->
    hold_en_out == !status_byte_three_out[7] &&
    pin_reset_en_out == status_byte_three_out[7])
    else $error("hold or reset role wrong");
  a_mode_outputs: assert property (
    use_block_locks_out == status_byte_three_out[2] &&
    fast_clock_standby_out == status_byte_three_out[4])
    else $error("mode outputs differ from byte three");
endmodule : flash_status_sva

bind flash_status_protect_regs flash_status_sva #(
  .WRITE_CYCLES(WRITE_CYCLES)
) chk (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .soft_reset_in(soft_reset_in), .op_valid_in(op_valid_in),
  .op_code_in(op_code_in), .status_write_in(status_write_in),
  .protect_pin_n_in(protect_pin_n_in),
  .status_byte_one_out(status_byte_one_out),
  .status_byte_two_out(status_byte_two_out),
  .status_byte_three_out(status_byte_three_out),
  .write_permit_latch_out(write_permit_latch_out), .busy_out(busy_out),
  .use_block_locks_out(use_block_locks_out),
  .fast_clock_standby_out(fast_clock_standby_out),
  .data_line_two_en_out(data_line_two_en_out),
  .data_line_three_en_out(data_line_three_en_out),
  .hold_en_out(hold_en_out), .pin_reset_en_out(pin_reset_en_out)
);

// [tb/status_host_model.sv]
// host model issuing instruction and status write strobes
// assumes a free-running clk_in; strobes change on falling edges
`timescale 1ns/1ps
module status_host_model (
  // clock
  input  wire logic clk_in,
  // strobes to the status block
  output logic       op_valid_out,
  output logic [7:0] op_code_out,
  output logic       write_out,
  output logic [1:0] count_out,
  output logic [7:0] byte_one_out,
  output logic [7:0] byte_two_out,
  output logic [7:0] byte_three_out
);
  initial begin
    {op_valid_out, write_out, op_code_out, count_out} = '0;
    {byte_one_out, byte_two_out, byte_three_out} = '0;
  end
  // one-cycle strobe; code turns to its inverse once released
  task automatic send_op(input logic [7:0] code);
    @(negedge clk_in);
    op_code_out = code;
    op_valid_out = 1'b1;
    @(negedge clk_in);
    op_valid_out = 1'b0;
    op_code_out = ~code;
  endtask : send_op
  // status write; stale bytes are scrambled so none is read by luck
  task automatic send_write(input logic [1:0] n, input logic [7:0] a, b, c);
    @(negedge clk_in);
    {count_out, byte_one_out, byte_two_out, byte_three_out} = {n, a, b, c};
    write_out = 1'b1;
    @(negedge clk_in);
    write_out = 1'b0;
    {byte_one_out, byte_two_out, byte_three_out} = ~{a, b, c};
  endtask : send_write
endmodule : status_host_model

// [tb/test_flash_status_protect_regs.sv]
// self-checking bench for the status and protection register bank
// assumes the bound checker and the host model beside it
`timescale 1ns/1ps
module test_flash_status_protect_regs;
  logic clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, soft_reset_in = 1'b0;
  logic array_start_in = 1'b0, array_done_in = 1'b0, protect_pin_n_in = 1'b1;
  logic lock_set_in = 1'b0, lock_clear_in = 1'b0, lock_all_in = 1'b0;
  logic [8:0] lock_index_in = 9'h005;
  logic op_valid, write, latch, busy, blk, fast, lbit, d2, d3, hold, prst;
  logic [1:0] cnt;
  logic [2:0] otp;
  logic [6:0] pct;
  logic [7:0] code, b1, b2, b3, s1, s2, s3, e1, e2, e3, elatch;
  int mismatches = 0, checked = 0, seed = 32'h085d3a45;
  always #12.5 clk_in = ~clk_in;
  status_host_model host (.clk_in(clk_in), .op_valid_out(op_valid),
    .op_code_out(code), .write_out(write), .count_out(cnt),
    .byte_one_out(b1), .byte_two_out(b2), .byte_three_out(b3));
  flash_status_protect_regs dut (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .soft_reset_in(soft_reset_in), .op_valid_in(op_valid),
    .op_code_in(code), .status_write_in(write), .status_write_count_in(cnt),
    .write_byte_one_in(b1), .write_byte_two_in(b2), .write_byte_three_in(b3),
    .array_start_in(array_start_in), .array_done_in(array_done_in),
    .lock_set_in(lock_set_in), .lock_clear_in(lock_clear_in),
    .lock_all_in(lock_all_in), .lock_index_in(lock_index_in),
    .protect_pin_n_in(protect_pin_n_in), .status_byte_one_out(s1),
    .status_byte_two_out(s2), .status_byte_three_out(s3),
    .write_permit_latch_out(latch), .busy_out(busy),
    .use_block_locks_out(blk), .fast_clock_standby_out(fast),
    .otp_locked_out(otp), .lock_bit_out(lbit), .data_line_two_en_out(d2),
    .data_line_three_en_out(d3), .hold_en_out(hold),
    .pin_reset_en_out(prst), .strength_pct_out(pct));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [6:0] pct_of(input logic [1:0] s);
    case (s)
      2'h0: return 7'h32;
      2'h1: return 7'h19;
      2'h2: return 7'h4b;
      default: return 7'h64;
    endcase
  endfunction : pct_of
  // guard mode decides; a four line part has no protect pin
  function automatic logic allowed();
    case ({e2[0], e1[7]})
      2'h0: return elatch[0];
      2'h1: return elatch[0] && (protect_pin_n_in || e2[1]);
      default: return 1'b0;
    endcase
  endfunction : allowed
  task automatic check_all();
    check(s1 & 8'hfc, e1 & 8'hfc);
    check(latch, elatch);
    check(s2, e2);
    check(s3, e3);
    check(pct, pct_of(e3[6:5]));
    check({d2, d3, hold, prst}, e2[1] ? 4'hc : {2'h0, ~e3[7], e3[7]});
    check({blk, fast, otp}, {e3[2], e3[4], e2[5:3]});
  endtask : check_all
  task automatic pulse(ref logic s);
    @(negedge clk_in) s = 1'b1;
    @(negedge clk_in) s = 1'b0;
  endtask : pulse
  task automatic op(input logic [7:0] c);
    host.send_op(c);
    case (c)
      8'h06: elatch = 8'h01;
      8'h04: elatch = 8'h00;
      8'h75: e2 = e2 | 8'h84;
      default: e2 = e2 & 8'h7b;
    endcase
    check_all();
  endtask : op
  // busy and pause bits are never written; otp bits only OR in
  task automatic do_write(input logic [1:0] n, input logic [7:0] a, b, c);
    int cyc;
    logic ok;
    cyc = 0;
    ok = allowed();
    if (ok) begin
      e1 = (e1 & 8'h03) | (a & 8'hfc);
      if (n >= 2'h2) e2 = (e2 & 8'hbc) | (b & 8'h7b);
      if (n == 2'h3) e3 = (e3 & 8'h0a) | (c & 8'hf5);
    end
    host.send_write(n, a, b, c);
    while (busy !== 1'b0 && cyc < 50) begin
      @(negedge clk_in);
      cyc++;
    end
    elatch = 8'h00;
    check(8'(cyc), ok ? 8'h04 : 8'h00);
    check_all();
  endtask : do_write
  initial begin
    #(25 * 4000);
    mismatches++;
    complete_run();
  end
  initial begin
    int i;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in) rst_in = 1'b0;
    {e1, e2, e3, elatch} = {8'h00, 8'h00, 8'h10, 8'h00};
    check_all();
    check(lbit, 1'b1);
    op(8'h06);
    op(8'h04);
    do_write(2'h3, 8'h1c, 8'h40, 8'h00);
    $display("test latch done");
    for (i = 0; i < 8; i++) begin
      op(8'h06);
      do_write(i % 3 + 1, $random(seed) & 8'h7f, $random(seed) & 8'hc2,
        $random(seed));
    end
    $display("test random writes done");
    op(8'h75);
    op(8'h7a);
    op(8'h06);
    do_write(2'h2, 8'h00, 8'h08, 8'h00);
    op(8'h06);
    do_write(2'h2, 8'h00, 8'h00, 8'h00);
    $display("test pause and otp done");
    op(8'h06);
    pulse(array_start_in);
    check(busy, 1'b1);
    pulse(array_done_in);
    elatch = 8'h00;
    check(busy, 1'b0);
    check_all();
    lock_index_in = 9'h12c;
    #1 check(lbit, 1'b1);
    lock_index_in = 9'h005;
    pulse(lock_clear_in);
    check(lbit, 1'b0);
    pulse(lock_set_in);
    check(lbit, 1'b1);
    pulse(lock_clear_in);
    pulse(lock_all_in);
    check(lbit, 1'b1);
    $display("test array and locks done");
    op(8'h06);
    do_write(2'h1, 8'h80, 8'h00, 8'h00);
    protect_pin_n_in = 1'b0;
    op(8'h06);
    do_write(2'h1, 8'h9c, 8'h00, 8'h00);
    protect_pin_n_in = 1'b1;
    op(8'h06);
    do_write(2'h2, 8'h08, 8'h01, 8'h00);
    op(8'h06);
    do_write(2'h3, 8'h9c, 8'h41, 8'hff);
    pulse(soft_reset_in);
    e2[0] = 1'b0;
    check_all();
    check(lbit, 1'b1);
    $display("test pin and lockdown done");
    op(8'h06);
    do_write(2'h2, 8'h80, 8'h01, 8'h00);
    op(8'h06);
    do_write(2'h3, 8'h00, 8'h00, 8'h00);
    pulse(soft_reset_in);
    check_all();
    $display("test permanent guard done");
    // enable low: write enable and suspend must leave no trace
    ce_in = 1'b0;
    host.send_op(8'h06);
    host.send_op(8'h75);
    check_all();
    ce_in = 1'b1;
    $display("test clock enable done");
    complete_run();
  end
endmodule : test_flash_status_protect_regs
